// file: design/sbc_spi_pkg.sv
package sbc_spi_pkg;
    // register addresses
    localparam logic [3:0] A_MODE = 4'h0;
    localparam logic [3:0] A_VOLT_ALIAS = 4'h1;
    localparam logic [3:0] A_WAKE = 4'h2;
    localparam logic [3:0] A_WAKE_ALIAS = 4'h3;
    localparam logic [3:0] A_LINE = 4'h4;
    localparam logic [3:0] A_LINE_ALIAS = 4'h5;
    localparam logic [3:0] A_HIGH = 4'h6;
    localparam logic [3:0] A_HIGH_ALIAS = 4'h7;
    localparam logic [3:0] A_LOW = 4'h8;
    localparam logic [3:0] A_LOW_ALIAS = 4'h9;
    localparam logic [3:0] A_TIMING = 4'ha;
    localparam logic [3:0] A_TIMING_ALIAS = 4'hb;
    localparam logic [3:0] A_AMUX = 4'hc;
    localparam logic [3:0] A_CONFIG = 4'hd;
    localparam logic [3:0] A_IRQ = 4'he;
    localparam logic [3:0] A_IRQ_ALIAS = 4'hf;
    // field positions
    localparam int MODE_OVERVOLTAGE_SHUTDOWN_ENABLE = 3;
    localparam int LINE_RECEIVE_ONLY_BIT = 2;
    localparam int LSTAT_RX_SHORT_FLAG = 3;
    localparam int LSTAT_TXD = 2;
    localparam int LSTAT_OT = 1;
    localparam int MASK_HS = 3;
    localparam int MASK_LS = 2;
    localparam int MASK_LINE = 1;
    localparam int MASK_VOLT = 0;
    localparam int ISR_LIN_WAKE = 1;
    // reset values
    localparam logic [3:0] WAKE_CTRL_RST = 4'hf;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] ALL_SYNC_RST = 4'hf;
    // frame
    localparam logic [3:0] FRAME_BITS = 4'h8;
    localparam logic [3:0] HALF_BITS = 4'h4;
    localparam logic [3:0] CNT_SAT = 4'hf;
    localparam int CNT_W = 26;
    // timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TXD_STUCK_MS = 1000;
    localparam int unsigned TXD_STUCK_CYC = (CLK_HZ / 1000) * TXD_STUCK_MS;
    localparam int unsigned WAKE_DOMINANT_US = 150;
    localparam int unsigned WAKE_CYC = (CLK_HZ / 1_000_000) * WAKE_DOMINANT_US;
    // operating modes, coded as the mode select bits
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_STOP = 2'b01,
        MODE_SLEEP = 2'b10,
        MODE_NORMAL_WD = 2'b11
    } mode_type;
endpackage

// file: design/sbc_spi_register_interface.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_register_interface #(
    parameter int unsigned TXD_STUCK_CYCLES = sbc_spi_pkg::TXD_STUCK_CYC,
    parameter int unsigned WAKE_CYCLES = sbc_spi_pkg::WAKE_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_mode,
    input wire logic ext_rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic txd,
    input wire logic lin_bus,
    input wire logic lin_ot_cond,
    input wire logic rx_short_cond,
    input wire logic vs_ov,
    input wire logic vs_uv,
    input wire logic vdd_ot,
    input wire logic [3:0] wake_inputs,
    input wire logic [3:0] hs_status,
    input wire logic [3:0] ls_status,
    input wire logic [3:0] wd_status,
    output logic lin_tx_en,
    output logic rxd,
    output sbc_spi_pkg::mode_type op_mode,
    output logic wd_clear,
    output logic drv_shutdown,
    output logic wake_reset,
    output logic irq_n,
    output logic [3:0] wake_enable,
    output logic [3:0] line_control,
    output logic [3:0] high_driver_control,
    output logic [3:0] low_driver_control,
    output logic [3:0] timing_control,
    output logic [3:0] analog_select,
    output logic [3:0] configuration
);
    import sbc_spi_pkg::*;

    // picks the lower reply nibble for an address; unmapped addresses read zero
    function automatic logic [3:0] status_select(input logic [3:0] addr, input logic [27:0] st);
        logic [3:0] res;
        res = 4'h0;
        unique case (addr)
            A_MODE, A_VOLT_ALIAS: res = st[3:0];
            A_WAKE, A_WAKE_ALIAS: res = st[7:4];
            A_LINE, A_LINE_ALIAS: res = st[11:8];
            A_HIGH, A_HIGH_ALIAS: res = st[15:12];
            A_LOW, A_LOW_ALIAS: res = st[19:16];
            A_TIMING, A_TIMING_ALIAS: res = st[23:20];
            A_IRQ, A_IRQ_ALIAS: res = st[27:24];
            A_AMUX, A_CONFIG: res = 4'h0;
        endcase
        return res;
    endfunction

    // ---------------- link side, clocked by the serial clock ----------------
    logic [3:0] rx_cnt_r; // sampling edges seen in this frame
    logic [7:0] rx_byte_r; // address then control, msb first
    logic [3:0] tx_cnt_r; // output edges seen in this frame
    logic [3:0] tx_addr_r; // address held once all four bits are in
    logic [3:0] cur_addr; // address used for the lower reply nibble
    logic [3:0] cur_stat; // status nibble picked for this frame
    logic [7:0] frame_byte_r; // last frame, held from chip select rise
    logic frame_ok_r; // last frame had exactly eight samples
    logic [27:0] snap_status_r; // status frozen while chip select is low
    logic [3:0] snap_sum_r; // summary frozen while chip select is low

    // sample on the falling edge; chip select high clears for the next frame
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            rx_cnt_r <= 4'h0;
            rx_byte_r <= 8'h00;
        end else begin
            rx_byte_r <= {rx_byte_r[6:0], spi_mosi};
            if (rx_cnt_r != CNT_SAT) begin
                rx_cnt_r <= rx_cnt_r + 4'h1; // saturates so a long frame never wraps to eight
            end
        end
    end

    // the address is complete before the fifth rising edge
    assign cur_addr = (tx_cnt_r == HALF_BITS) ? rx_byte_r[3:0] : tx_addr_r;
    assign cur_stat = status_select(cur_addr, snap_status_r);

    // shift out on the rising edge: summary first, then the addressed status
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            tx_cnt_r <= 4'h0;
            tx_addr_r <= 4'h0;
            spi_miso <= 1'b0;
        end else begin
            if (tx_cnt_r < HALF_BITS) begin
                spi_miso <= snap_sum_r[3 - tx_cnt_r[1:0]];
            end else if (tx_cnt_r < FRAME_BITS) begin
                spi_miso <= cur_stat[3 - tx_cnt_r[1:0]];
            end else begin
                spi_miso <= 1'b0; // extra clocks shift zeros
            end
            if (tx_cnt_r == HALF_BITS) begin
                tx_addr_r <= rx_byte_r[3:0];
            end
            if (tx_cnt_r != CNT_SAT) begin
                tx_cnt_r <= tx_cnt_r + 4'h1;
            end
        end
    end

    // chip select rise ends the frame: hold the byte for the core
    always_ff @(posedge spi_cs_n) begin
        frame_byte_r <= rx_byte_r;
        frame_ok_r <= (rx_cnt_r == FRAME_BITS);
    end

    // ---------------- core side, clocked by mclk ----------------
    logic [3:0] sync1_r; // first stage, read only by the second
    logic [3:0] sync2_r; // chip select, txd, bus, reset pin
    logic cs_prev_r; // synchronised chip select one cycle back
    logic cs_s;
    logic txd_s;
    logic lin_s;
    logic ext_s;

    // two flops for every pin; the synchronised chip select rise marks a finished
    // frame, and the held byte has settled long before that rise shows up here
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_r <= ALL_SYNC_RST;
            sync2_r <= ALL_SYNC_RST;
            cs_prev_r <= 1'b1; // idle level, so no false frame after reset
        end else begin
            sync1_r <= {spi_cs_n, txd, lin_bus, ext_rst_n};
            sync2_r <= sync1_r;
            cs_prev_r <= sync2_r[3];
        end
    end
    assign cs_s = sync2_r[3];
    assign txd_s = sync2_r[2];
    assign lin_s = sync2_r[1];
    assign ext_s = sync2_r[0];

    // frame decode; the held byte is stable until the next chip select rise
    logic frame_evt;
    logic wr_ok;
    logic [3:0] f_addr;
    logic [3:0] f_ctrl;
    logic soft_rst;
    assign frame_evt = cs_s & ~cs_prev_r;
    assign wr_ok = frame_evt & frame_ok_r;
    assign f_addr = frame_byte_r[7:4];
    assign f_ctrl = frame_byte_r[3:0];
    assign soft_rst = reset_mode | ~ext_s;

    // state and flags
    logic overvoltage_shutdown_enable_r;
    logic stop_receive_only_bit_r; // receive-only as it stood at stop entry
    logic power_on_r;
    logic txd_flag_r;
    logic txd_shut_r;
    logic short_flag_r;
    logic ot_flag_r;
    logic lin_wake_r;
    logic lin_prev_r;
    logic [3:0] irq_mask_r;
    logic [CNT_W-1:0] txd_cnt_r;
    logic [CNT_W-1:0] dom_cnt_r;
    logic stuck_set;
    logic line_err;
    logic wake_evt;
    logic wake_armed;
    logic read_line;
    logic [3:0] volt_stat;
    logic [3:0] line_stat;
    logic [3:0] wake_stat;
    logic [3:0] irq_src;

    assign volt_stat = {vs_ov, vs_uv, vdd_ot, power_on_r};
    assign line_stat = {short_flag_r, txd_flag_r, ot_flag_r, 1'b0};
    assign wake_stat = wake_inputs & wake_enable; // disabled inputs read zero
    assign irq_src = {2'b00, lin_wake_r, 1'b0};
    assign read_line = wr_ok & (f_addr[3:1] == A_LINE[3:1]);

    // snapshot refreshes while chip select is high and freezes for the frame,
    // so the serial side only ever reads a settled word
    always_ff @(posedge mclk) begin
        if (rst) begin
            snap_status_r <= 28'h0000000;
            snap_sum_r <= 4'h0;
        end else if (cs_s) begin
            snap_status_r <= {irq_src, wd_status, ls_status, hs_status, line_stat, wake_stat, volt_stat};
            snap_sum_r <= {|volt_stat, |line_stat, |hs_status, |ls_status};
        end
    end

    // output enable follows inverted chip select, three mclk cycles late
    always_ff @(posedge mclk) begin
        if (rst) begin
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= ~cs_s;
        end
    end

    // txd dominant timer, cleared whenever txd is recessive
    assign stuck_set = ~txd_s & (txd_cnt_r == CNT_W'(TXD_STUCK_CYCLES - 1));
    always_ff @(posedge mclk) begin
        if (rst || txd_s) begin
            txd_cnt_r <= '0;
        end else if (txd_cnt_r != CNT_W'(TXD_STUCK_CYCLES)) begin
            txd_cnt_r <= txd_cnt_r + CNT_W'(1);
        end
    end

    // txd shutdown flag lasts only while txd stays low; the receive-only bit set by the same fault keeps the driver off
    always_ff @(posedge mclk) begin
        if (rst || txd_s) begin
            txd_shut_r <= 1'b0;
        end else if (stuck_set) begin
            txd_shut_r <= 1'b1;
        end
    end

    // line flags: a new fault wins over a clearing read in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            txd_flag_r <= 1'b0;
            short_flag_r <= 1'b0;
            ot_flag_r <= 1'b0;
        end else begin
            txd_flag_r <= stuck_set | (txd_flag_r & ~(read_line & txd_s));
            short_flag_r <= rx_short_cond | (short_flag_r & ~read_line);
            ot_flag_r <= lin_ot_cond | (ot_flag_r & ~read_line);
        end
    end
    assign line_err = stuck_set | (rx_short_cond & ~short_flag_r) | (lin_ot_cond & ~ot_flag_r);

    // power-on flag: only power-on sets it, any mode/voltage access clears it
    always_ff @(posedge mclk) begin
        if (rst) begin
            power_on_r <= 1'b1;
        end else if (wr_ok && f_addr[3:1] == A_MODE[3:1]) begin
            power_on_r <= 1'b0;
        end
    end

    // mode control: writes decode the mode bits, a sleep wake returns to normal
    always_ff @(posedge mclk) begin
        if (rst) begin
            overvoltage_shutdown_enable_r <= 1'b1;
            op_mode <= MODE_NORMAL;
            stop_receive_only_bit_r <= 1'b0;
            wd_clear <= 1'b0;
        end else begin
            wd_clear <= 1'b0;
            if (soft_rst) begin
                op_mode <= MODE_NORMAL;
            end else if (wake_evt && op_mode == MODE_SLEEP) begin
                op_mode <= MODE_NORMAL;
            end else if (wr_ok && f_addr == A_MODE) begin
                overvoltage_shutdown_enable_r <= f_ctrl[MODE_OVERVOLTAGE_SHUTDOWN_ENABLE];
                unique case (mode_type'(f_ctrl[1:0]))
                    MODE_NORMAL: op_mode <= MODE_NORMAL;
                    MODE_STOP: begin
                        op_mode <= MODE_STOP;
                        stop_receive_only_bit_r <= line_control[LINE_RECEIVE_ONLY_BIT];
                    end
                    MODE_SLEEP: op_mode <= MODE_SLEEP;
                    MODE_NORMAL_WD: begin
                        op_mode <= MODE_NORMAL;
                        wd_clear <= 1'b1;
                    end
                endcase
            end
        end
    end

    // control registers written at even addresses and at A_CONFIG, other odd addresses only read
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_enable <= WAKE_CTRL_RST;
            line_control <= CTRL_RST;
            high_driver_control <= CTRL_RST;
            low_driver_control <= CTRL_RST;
            timing_control <= CTRL_RST;
            analog_select <= CTRL_RST;
            configuration <= CTRL_RST;
            irq_mask_r <= CTRL_RST;
        end else if (soft_rst) begin
            wake_enable <= WAKE_CTRL_RST;
            line_control[LINE_RECEIVE_ONLY_BIT] <= 1'b0;
            high_driver_control <= CTRL_RST;
            low_driver_control <= CTRL_RST;
        end else begin
            if (wr_ok) begin
                unique case (f_addr)
                    A_WAKE: wake_enable <= f_ctrl;
                    A_LINE: line_control <= f_ctrl;
                    A_HIGH: high_driver_control <= f_ctrl;
                    A_LOW: low_driver_control <= f_ctrl;
                    A_TIMING: timing_control <= f_ctrl;
                    A_AMUX: analog_select <= f_ctrl;
                    A_CONFIG: configuration <= f_ctrl;
                    A_IRQ: irq_mask_r <= f_ctrl;
                    default: ; // mode is handled above, the other odd addresses write nothing
                endcase
            end
            if (line_err) begin
                line_control[LINE_RECEIVE_ONLY_BIT] <= 1'b1;
            end
        end
    end

    // bus dominant timer for wake-up, cleared on every recessive level
    assign wake_armed = (op_mode == MODE_STOP && !stop_receive_only_bit_r) || op_mode == MODE_SLEEP;
    assign wake_evt = wake_armed & lin_s & ~lin_prev_r & (dom_cnt_r >= CNT_W'(WAKE_CYCLES));
    always_ff @(posedge mclk) begin
        if (rst) begin
            dom_cnt_r <= '0;
            lin_prev_r <= 1'b1;
        end else begin
            lin_prev_r <= lin_s;
            if (lin_s) begin
                dom_cnt_r <= '0;
            end else if (dom_cnt_r != CNT_W'(WAKE_CYCLES)) begin
                dom_cnt_r <= dom_cnt_r + CNT_W'(1);
            end
        end
    end

    // wake source: set wins over the clearing read of the source register
    always_ff @(posedge mclk) begin
        if (rst) begin
            lin_wake_r <= 1'b0;
            wake_reset <= 1'b0;
        end else begin
            lin_wake_r <= wake_evt | (lin_wake_r & ~(wr_ok && f_addr[3:1] == A_IRQ[3:1]));
            wake_reset <= wake_evt & (op_mode == MODE_SLEEP);
        end
    end

    // pin-facing outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            lin_tx_en <= 1'b0;
            rxd <= 1'b1;
            drv_shutdown <= 1'b0;
            irq_n <= 1'b1;
        end else begin
            // driver only in normal, not receive-only, no fault
            lin_tx_en <= (op_mode == MODE_NORMAL) & ~line_control[LINE_RECEIVE_ONLY_BIT] & ~txd_shut_r
                         & ~lin_ot_cond & ~rx_short_cond;
            if (op_mode == MODE_NORMAL || (op_mode == MODE_STOP && stop_receive_only_bit_r)) begin
                rxd <= lin_s;
            end else begin
                rxd <= 1'b1;
            end
            drv_shutdown <= overvoltage_shutdown_enable_r & vs_ov;
            irq_n <= ~((irq_mask_r[MASK_LINE] & (|line_stat))
                       | (lin_wake_r & (op_mode == MODE_STOP))
                       | (irq_mask_r[MASK_VOLT] & (|volt_stat[3:1]))
                       | (irq_mask_r[MASK_HS] & (&hs_status))
                       | (irq_mask_r[MASK_LS] & (&ls_status)));
        end
    end
endmodule
`default_nettype wire

// file: verification/sbc_spi_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_monitor #(
    parameter int unsigned TXD_STUCK_CYCLES = 200,
    parameter int unsigned WAKE_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic txd,
    input wire logic lin_bus,
    input wire logic vs_ov,
    input wire logic [3:0] hs_status,
    input wire logic [3:0] ls_status,
    input wire logic lin_tx_en,
    input wire logic rxd,
    input wire sbc_spi_pkg::mode_type op_mode,
    input wire logic drv_shutdown,
    input wire logic wake_reset
);
    import sbc_spi_pkg::*;
    // sclk rises seen in the frame; deselect clears it like the link flops
    logic [3:0] rise_cnt;
    // raw low-time counters; they saturate so a long hold cannot wrap
    int unsigned txd_low_cnt;
    int unsigned lin_low_cnt;

    // count rises, bit 7 goes out on the first one
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            rise_cnt <= 4'h0;
        end else if (rise_cnt != 4'hf) begin
            rise_cnt <= rise_cnt + 4'h1;
        end
    end

    // dominant time on the transmit input
    always_ff @(posedge mclk) begin
        if (rst || txd) begin
            txd_low_cnt <= 0;
        end else if (txd_low_cnt < 100000) begin
            txd_low_cnt <= txd_low_cnt + 1;
        end
    end

    // dominant time on the bus
    always_ff @(posedge mclk) begin
        if (rst || lin_bus) begin
            lin_low_cnt <= 0;
        end else if (lin_low_cnt < 100000) begin
            lin_low_cnt <= lin_low_cnt + 1;
        end
    end

    oe_drive_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(spi_cs_n) |-> ##[1:4] spi_miso_oe) else $error("miso not driven after select");
    miso_hiz_a: assert property (@(posedge mclk) disable iff (rst)
        spi_cs_n [*5] |-> !spi_miso_oe) else $error("miso driven while deselected");
    hss_bit_a: assert property (@(negedge spi_sclk) disable iff (spi_cs_n)
        rise_cnt == 4'h3 |-> spi_miso == (|hs_status)) else $error("high side summary wrong");
    lss_bit_a: assert property (@(negedge spi_sclk) disable iff (spi_cs_n)
        rise_cnt == 4'h4 |-> spi_miso == (|ls_status)) else $error("low side summary wrong");
    txd_stuck_a: assert property (@(posedge mclk) disable iff (rst)
        txd_low_cnt == TXD_STUCK_CYCLES + 8 |-> !lin_tx_en) else $error("stuck txd not shut off");
    ov_shutdown_a: assert property (@(posedge mclk) disable iff (rst)
        (!vs_ov) [*3] |-> !drv_shutdown) else $error("driver shutdown without overvoltage");
    mode_code_a: assert property (@(posedge mclk) disable iff (rst)
        op_mode != MODE_NORMAL_WD) else $error("clear code held as a mode");
    wake_reset_a: assert property (@(posedge mclk) disable iff (rst)
        wake_reset |-> ($past(op_mode) == MODE_SLEEP) ##[0:2] (op_mode == MODE_NORMAL))
        else $error("wake reset outside sleep");
    short_wake_a: assert property (@(posedge mclk) disable iff (rst)
        ($rose(lin_bus) && lin_low_cnt + 3 < WAKE_CYCLES) |=> (!wake_reset) [*6])
        else $error("wake on short dominant");
    rx_follow_a: assert property (@(posedge mclk) disable iff (rst)
        (op_mode == MODE_NORMAL && !lin_bus) [*4] |-> !rxd) else $error("receiver not following bus");
endmodule

bind sbc_spi_register_interface sbc_spi_monitor #(
    .TXD_STUCK_CYCLES(TXD_STUCK_CYCLES),
    .WAKE_CYCLES(WAKE_CYCLES)
) sbc_spi_monitor_i (.mclk, .rst, .spi_cs_n, .spi_sclk, .spi_miso, .spi_miso_oe, .txd, .lin_bus,
    .vs_ov, .hs_status, .ls_status, .lin_tx_en, .rxd, .op_mode, .drv_shutdown, .wake_reset);
`default_nettype wire

// file: verification/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    // serial clock stands low between frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b1;
    end

    // one frame of n clocks, address then control, msb first
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        logic [15:0] sh;
        sh = {tx, 8'h00};
        rx = 8'h00;
        cs_n = 1'b0;
        #100;
        for (int k = 0; k < n; k++) begin
            sclk = 1'b1;
            mosi = sh[15];
            sh = sh << 1;
            #3;
            sclk = 1'b0;
            // a floating line reads as junk, so take the inverse
            rx = {rx[6:0], miso_oe ? miso : ~miso};
            #3;
        end
        #20;
        cs_n = 1'b1;
        mosi = ~mosi;
        #100;
    endtask
endmodule
`default_nettype wire

// file: verification/test_sbc_spi_register_interface.sv
`timescale 1ns/1ps
`default_nettype none
module test_sbc_spi_register_interface;
    import sbc_spi_pkg::*;
    // stimulus
    logic mclk = 1'b0, rst = 1'b1, reset_mode = 1'b0, ext_rst_n = 1'b1;
    logic txd = 1'b1, lin_bus = 1'b1, lin_ot_cond = 1'b0, rx_short_cond = 1'b0;
    logic vs_ov = 1'b0, vs_uv = 1'b0, vdd_ot = 1'b0;
    logic [3:0] wake_inputs = 4'h0, hs_status = 4'h6, ls_status = 4'h1, wd_status = 4'h4;
    // link wires and design outputs
    wire logic spi_cs_n, spi_sclk, spi_mosi;
    logic spi_miso, spi_miso_oe, lin_tx_en, rxd, wd_clear, drv_shutdown, wake_reset, irq_n;
    mode_type op_mode;
    logic [3:0] wake_enable, line_control, high_driver_control, low_driver_control;
    logic [3:0] timing_control, analog_select, configuration;
    int failures = 0, cmp_count = 0, wd_seen = 0, wake_seen = 0;

    // short counts keep the run brief
    sbc_spi_register_interface #(.TXD_STUCK_CYCLES(200), .WAKE_CYCLES(20)) sbc_spi_register_interface_i (
        .mclk, .rst, .reset_mode, .ext_rst_n, .spi_cs_n, .spi_sclk, .spi_mosi, .spi_miso, .spi_miso_oe,
        .txd, .lin_bus, .lin_ot_cond, .rx_short_cond, .vs_ov, .vs_uv, .vdd_ot, .wake_inputs, .hs_status,
        .ls_status, .wd_status, .lin_tx_en, .rxd, .op_mode, .wd_clear, .drv_shutdown, .wake_reset, .irq_n,
        .wake_enable, .line_control, .high_driver_control, .low_driver_control, .timing_control,
        .analog_select, .configuration);
    spi_master_model spi_master_model_i (.cs_n(spi_cs_n), .sclk(spi_sclk), .mosi(spi_mosi),
        .miso(spi_miso), .miso_oe(spi_miso_oe));

    always #10 mclk = ~mclk;

    // pulses are one cycle wide, so count them as they pass
    always @(posedge mclk) begin
        if (wd_clear === 1'b1) begin
            wd_seen++;
        end
        if (wake_reset === 1'b1) begin
            wake_seen++;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // frame, then let the commit cross into the core domain
    task automatic frame(input logic [3:0] a, input logic [3:0] c, input int n, output logic [7:0] r);
        spi_master_model_i.xfer({a, c}, n, r);
        step(6);
    endtask

    task automatic xchk(input logic [3:0] a, input logic [3:0] c, input logic [7:0] e);
        logic [7:0] r;
        frame(a, c, 8, r);
        chk(r, e);
    endtask

    task automatic lin_pulse(input int lo, input int hi);
        lin_bus = 1'b0;
        step(lo);
        lin_bus = 1'b1;
        step(hi);
    endtask

    function automatic logic [27:0] ctls();
        return {wake_enable, line_control, high_driver_control, low_driver_control,
            timing_control, analog_select, configuration};
    endfunction

    task automatic t_reset();
        logic [7:0] r;
        chk(ctls(), 28'hf000000);
        chk(irq_n, 1'b1);
        xchk(A_VOLT_ALIAS, 4'h0, 8'hb1);
        xchk(A_VOLT_ALIAS, 4'h0, 8'h30);
        vs_ov = 1'b1;
        step(3);
        chk(drv_shutdown, 1'b1);
        xchk(A_MODE, 4'h0, 8'hb8);
        chk(drv_shutdown, 1'b0);
        vs_ov = 1'b0;
        frame(A_MODE, 4'h8, 8, r);
    endtask

    task automatic t_regs();
        logic [3:0] adr [7] = '{A_WAKE, A_LINE, A_HIGH, A_LOW, A_TIMING, A_AMUX, A_CONFIG};
        logic [7:0] rep [7] = '{8'h30, 8'h30, 8'h36, 8'h31, 8'h34, 8'h30, 8'h30};
        logic [27:0] e;
        logic [7:0] r;
        e = 28'hf000000;
        for (int i = 0; i < 7; i++) begin
            frame(adr[i], 4'h9 + 4'(i), 8, r);
            chk(r, rep[i]);
            e[27 - 4 * i -: 4] = 4'h9 + 4'(i);
            chk(ctls(), e);
        end
        frame(A_WAKE, 4'h3, 7, r);
        frame(A_WAKE, 4'h3, 9, r);
        xchk(A_WAKE_ALIAS, 4'h3, 8'h30);
        chk(ctls(), e);
        reset_mode = 1'b1;
        step(2);
        reset_mode = 1'b0;
        step(3);
        chk(ctls(), 28'hfa00def);
        frame(A_HIGH, 4'h3, 8, r);
        ext_rst_n = 1'b0;
        step(4);
        ext_rst_n = 1'b1;
        step(4);
        chk(high_driver_control, 4'h0);
    endtask

    // codes 1, 2, 3, 0 with the shutdown enable kept set
    task automatic t_modes();
        logic [1:0] m;
        logic [7:0] r;
        int w;
        for (int i = 1; i <= 4; i++) begin
            m = 2'(i);
            w = wd_seen;
            frame(A_MODE, {2'b10, m}, 8, r);
            chk(op_mode, (m == 2'b11) ? 2'b00 : m);
            chk(wd_seen, w + ((m == 2'b11) ? 1 : 0));
        end
    endtask

    task automatic t_txd();
        logic [7:0] r;
        frame(A_IRQ, 4'h2, 8, r);
        frame(A_LINE, 4'h0, 8, r);
        lin_pulse(0, 0);
        txd = 1'b0;
        step(150);
        txd = 1'b1;
        step(3);
        txd = 1'b0;
        step(150);
        chk(lin_tx_en, 1'b1);
        step(70);
        chk(lin_tx_en, 1'b0);
        chk(irq_n, 1'b0);
        chk(line_control[LINE_RECEIVE_ONLY_BIT], 1'b1);
        xchk(A_LINE_ALIAS, 4'h0, 8'h74);
        txd = 1'b1;
        step(6);
        chk(lin_tx_en, 1'b0);
        xchk(A_LINE_ALIAS, 4'h0, 8'h74);
        xchk(A_LINE_ALIAS, 4'h0, 8'h30);
        frame(A_LINE, 4'h0, 8, r);
        chk(lin_tx_en, 1'b1);
        rx_short_cond = 1'b1;
        step(4);
        xchk(A_LINE_ALIAS, 4'h0, 8'h78);
        rx_short_cond = 1'b0;
        step(4);
        xchk(A_LINE_ALIAS, 4'h0, 8'h78);
        xchk(A_LINE_ALIAS, 4'h0, 8'h30);
        lin_ot_cond = 1'b1;
        step(4);
        xchk(A_LINE_ALIAS, 4'h0, 8'h72);
        lin_ot_cond = 1'b0;
        step(4);
        xchk(A_LINE_ALIAS, 4'h0, 8'h72);
        xchk(A_LINE_ALIAS, 4'h0, 8'h30);
    endtask

    task automatic t_wake();
        logic [7:0] r;
        frame(A_LINE, 4'h0, 8, r);
        frame(A_MODE, 4'h9, 8, r);
        lin_pulse(12, 3);
        lin_pulse(12, 8);
        chk(irq_n, 1'b1);
        lin_pulse(30, 6);
        chk(irq_n, 1'b0);
        xchk(A_IRQ_ALIAS, 4'h0, 8'h32);
        xchk(A_IRQ_ALIAS, 4'h0, 8'h30);
        frame(A_MODE, 4'ha, 8, r);
        lin_pulse(30, 6);
        chk(wake_seen, 1);
        chk(op_mode, MODE_NORMAL);
        xchk(A_IRQ_ALIAS, 4'h0, 8'h32);
        frame(A_LINE, 4'h4, 8, r);
        frame(A_MODE, 4'h9, 8, r);
        lin_bus = 1'b0;
        step(30);
        chk(rxd, 1'b0);
        lin_bus = 1'b1;
        step(6);
        chk(rxd, 1'b1);
        chk(irq_n, 1'b1);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // main sequence, reset held for four cycles
    initial begin
        repeat (4) @(posedge mclk);
        #1;
        rst = 1'b0;
        step(6);
        t_reset();
        t_regs();
        t_modes();
        t_txd();
        t_wake();
        conclude();
    end

    // several times the expected run length
    initial begin
        #300000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
